// ### logic/sar_conversion_sequencer.sv
// Successive-approximation conversion sequencer with serial result and configuration port
`timescale 1ns/10ps
module sar_conversion_sequencer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic conversionStartInput,
    input wire logic compHigh,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo,
    output logic sdoEn,
    output logic busy,
    output logic positiveSampleGroundSwitch,
    output logic negativeSampleGroundSwitch,
    output logic arraysToInputs,
    output logic [15:0] dacTrial,
    output logic powerDown
);
    localparam int STEP_TOTAL = sar_pkg::CODE_W * sar_pkg::CONV_TICK_CYC;

    function automatic logic [15:0] fmtCode(input logic [15:0] code, input logic bipolar);
        fmtCode = bipolar ? {~code[15], code[14:0]} : code;
    endfunction

    // Link side, clocked by the serial clock; a high start input ends the frame
    logic linkRst_n;
    logic [4:0] linkCnt, next_linkCnt;
    logic [29:0] outShift, next_outShift;
    logic [13:0] inShift, next_inShift;
    logic frameOn, next_frameOn;
    logic [13:0] cfgXfer, next_cfgXfer;
    logic cfgTgl, next_cfgTgl;
    logic [15:0] holdCode;
    logic [13:0] holdCfg;
    logic [29:0] frameWord;

    assign linkRst_n = rst_n & ~conversionStartInput;
    // Configuration follows the code only when readback was on for that conversion
    assign frameWord = {holdCode, holdCfg[sar_pkg::CFG_READBACK_BIT] ? holdCfg : 14'h0000};
    assign sdoEn = ~conversionStartInput;
    assign sdo = (linkCnt == 5'h00) ? frameWord[29] : outShift[29];

    always_comb begin
        next_linkCnt = linkCnt;
        next_frameOn = 1'b1;
        next_inShift = {inShift[12:0], sdi};
        next_cfgXfer = cfgXfer;
        next_cfgTgl = cfgTgl;
        if (linkCnt != 5'(sar_pkg::FRAME_W)) begin
            next_linkCnt = linkCnt + 5'h01;
        end
        if (linkCnt == 5'h00) begin
            next_outShift = {frameWord[28:0], 1'b0};
        end else begin
            next_outShift = {outShift[28:0], 1'b0};
        end
        if (linkCnt == 5'(sar_pkg::CFG_W - 1)) begin
            next_cfgXfer = {inShift[12:0], sdi};
            next_cfgTgl = ~cfgTgl;
        end
    end

    always_ff @(posedge sck or negedge linkRst_n) begin
        if (!linkRst_n) begin
            linkCnt <= 5'h00;
            outShift <= 30'h00000000;
            inShift <= 14'h0000;
            frameOn <= 1'b0;
        end else begin
            linkCnt <= next_linkCnt;
            outShift <= next_outShift;
            inShift <= next_inShift;
            frameOn <= next_frameOn;
        end
    end

    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            cfgXfer <= sar_pkg::CFG_RESET;
            cfgTgl <= 1'b0;
        end else begin
            cfgXfer <= next_cfgXfer;
            cfgTgl <= next_cfgTgl;
        end
    end

    // Pin and link crossings into the core clock
    logic [2:0] cnvSync, frameSync, tglSync;
    logic cnvLevel, next_cnvLevel, frameLevel, next_frameLevel, tglSeen, next_tglSeen;
    logic cnvRise, cfgEvt;

    always_comb begin
        next_cnvLevel = (cnvSync[1] == cnvSync[2]) ? cnvSync[2] : cnvLevel;
        next_frameLevel = (frameSync[1] == frameSync[2]) ? frameSync[2] : frameLevel;
        next_tglSeen = (tglSync[1] == tglSync[2]) ? tglSync[2] : tglSeen;
        cnvRise = (cnvSync[1] == cnvSync[2]) && cnvSync[2] && !cnvLevel;
        cfgEvt = (tglSync[1] == tglSync[2]) && (tglSync[2] != tglSeen);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnvSync <= 3'h0;
            frameSync <= 3'h0;
            tglSync <= 3'h0;
            cnvLevel <= 1'b0;
            frameLevel <= 1'b0;
            tglSeen <= 1'b0;
        end else begin
            cnvSync <= {cnvSync[1:0], conversionStartInput};
            frameSync <= {frameSync[1:0], frameOn};
            tglSync <= {tglSync[1:0], cfgTgl};
            cnvLevel <= next_cnvLevel;
            frameLevel <= next_frameLevel;
            tglSeen <= next_tglSeen;
        end
    end

    // Active configuration; a word caught mid-conversion applies to the next one
    logic [13:0] cfgActive, next_cfgActive;

    always_comb begin
        next_cfgActive = cfgEvt ? cfgXfer : cfgActive;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgActive <= sar_pkg::CFG_RESET;
        end else begin
            cfgActive <= next_cfgActive;
        end
    end

    // Conversion engine, paced by the internal conversion tick
    sar_pkg::sar_state_t state, next_state;
    logic [2:0] tickCnt, next_tickCnt;
    logic [3:0] bitIdx, next_bitIdx;
    logic [15:0] next_dacTrial;
    logic [13:0] cfgUsed, next_cfgUsed;
    logic [9:0] gapCnt, next_gapCnt;
    logic busyEn, next_busyEn;
    logic next_posSw, next_negSw, next_toInputs, next_powerDown, next_busy;
    logic tickDone, fillReady;

    always_comb begin
        tickDone = tickCnt == 3'(sar_pkg::CONV_TICK_CYC - 1);
        next_state = state;
        next_tickCnt = (state == sar_pkg::ACQ || tickDone) ? 3'h0 : tickCnt + 3'h1;
        next_bitIdx = bitIdx;
        next_dacTrial = dacTrial;
        next_cfgUsed = cfgUsed;
        next_busyEn = busyEn;
        next_gapCnt = (gapCnt != 10'h000) ? gapCnt - 10'h001 : gapCnt;
        if (state != sar_pkg::ACQ && !cnvLevel) begin
            next_busyEn = 1'b1;
        end
        unique case (state)
            sar_pkg::ACQ: begin
                if (cnvRise && gapCnt == 10'h000) begin
                    next_state = sar_pkg::OPEN;
                    next_gapCnt = 10'(sar_pkg::START_GAP_CYC - 1);
                    next_cfgUsed = cfgActive;
                    // Start edge itself sees the pin high; busy waits for a low level later
                    next_busyEn = 1'b0;
                end
            end
            sar_pkg::OPEN: begin
                if (tickDone) begin
                    next_state = sar_pkg::HOLD;
                end
            end
            sar_pkg::HOLD: begin
                if (tickDone) begin
                    next_state = sar_pkg::STEP;
                    next_dacTrial = sar_pkg::CODE_MSB;
                    next_bitIdx = 4'hF;
                end
            end
            sar_pkg::STEP: begin
                if (tickDone) begin
                    if (compHigh) begin
                        next_dacTrial[bitIdx] = 1'b0;
                    end
                    if (bitIdx == 4'h0) begin
                        next_state = sar_pkg::DONE;
                    end else begin
                        next_bitIdx = bitIdx - 4'h1;
                        next_dacTrial[bitIdx - 4'h1] = 1'b1;
                    end
                end
            end
            sar_pkg::DONE: begin
                // Waits here only while both buffer entries are still unread
                if (fillReady) begin
                    next_state = sar_pkg::ACQ;
                end
            end
            default: begin
                next_state = sar_pkg::ACQ;
            end
        endcase
        next_posSw = next_state == sar_pkg::ACQ;
        next_negSw = next_state == sar_pkg::ACQ;
        next_toInputs = next_state == sar_pkg::ACQ || next_state == sar_pkg::OPEN;
        next_powerDown = next_state == sar_pkg::ACQ;
        next_busy = next_state != sar_pkg::ACQ && next_busyEn;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= sar_pkg::ACQ;
            tickCnt <= 3'h0;
            bitIdx <= 4'h0;
            dacTrial <= 16'h0000;
            cfgUsed <= sar_pkg::CFG_RESET;
            gapCnt <= 10'h000;
            busyEn <= 1'b0;
            positiveSampleGroundSwitch <= 1'b1;
            negativeSampleGroundSwitch <= 1'b1;
            arraysToInputs <= 1'b1;
            powerDown <= 1'b1;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            tickCnt <= next_tickCnt;
            bitIdx <= next_bitIdx;
            dacTrial <= next_dacTrial;
            cfgUsed <= next_cfgUsed;
            gapCnt <= next_gapCnt;
            busyEn <= next_busyEn;
            positiveSampleGroundSwitch <= next_posSw;
            negativeSampleGroundSwitch <= next_negSw;
            arraysToInputs <= next_toInputs;
            powerDown <= next_powerDown;
            busy <= next_busy;
        end
    end

    // Two-entry result buffer; the output word is not replaced while a frame is being read
    logic [29:0] mem [2];
    logic [29:0] next_mem [2];
    logic wrPtr, next_wrPtr, rdPtr, next_rdPtr;
    logic [1:0] bufCount, next_bufCount;
    logic [15:0] next_holdCode;
    logic [13:0] next_holdCfg;
    logic fillValid, drainValid, drainReady, push, pop;

    always_comb begin
        fillValid = state == sar_pkg::DONE;
        fillReady = bufCount != 2'h2;
        drainValid = bufCount != 2'h0;
        drainReady = !frameLevel;
        push = fillValid && fillReady;
        pop = drainValid && drainReady;
        next_mem = mem;
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        next_holdCode = holdCode;
        next_holdCfg = holdCfg;
        if (push) begin
            next_mem[wrPtr] = {fmtCode(dacTrial, cfgUsed[sar_pkg::CFG_BIPOLAR_BIT]), cfgUsed};
            next_wrPtr = ~wrPtr;
        end
        if (pop) begin
            next_holdCode = mem[rdPtr][29:14];
            next_holdCfg = mem[rdPtr][13:0];
            next_rdPtr = ~rdPtr;
        end
        next_bufCount = bufCount + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem[0] <= 30'h00000000;
            mem[1] <= 30'h00000000;
            wrPtr <= 1'b0;
            rdPtr <= 1'b0;
            bufCount <= 2'h0;
            holdCode <= 16'h0000;
            holdCfg <= sar_pkg::CFG_RESET;
        end else begin
            mem <= next_mem;
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            bufCount <= next_bufCount;
            holdCode <= next_holdCode;
            holdCfg <= next_holdCfg;
        end
    end

    // Cycles spent deciding bits, for checking only
    logic [7:0] stepCyc;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stepCyc <= 8'h00;
        end else if (state == sar_pkg::STEP) begin
            stepCyc <= stepCyc + 8'h01;
        end else if (state == sar_pkg::ACQ) begin
            stepCyc <= 8'h00;
        end
    end

    start_conv_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == sar_pkg::ACQ && cnvRise && gapCnt == 10'h000) |=> state == sar_pkg::OPEN)
        else $error("start edge did not begin a conversion");
    switch_open_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == sar_pkg::OPEN |-> !positiveSampleGroundSwitch && !negativeSampleGroundSwitch
        && arraysToInputs)
        else $error("ground switches not opened before arrays leave inputs");
    arrays_ground_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state == sar_pkg::HOLD) |-> $past(state) == sar_pkg::OPEN && !arraysToInputs)
        else $error("arrays not tied to ground after switches opened");
    msb_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state == sar_pkg::STEP) |-> dacTrial == sar_pkg::CODE_MSB && bitIdx == 4'hF)
        else $error("approximation did not start at the top bit");
    step_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(state == sar_pkg::STEP) |-> stepCyc == 8'(STEP_TOTAL))
        else $error("wrong number of decision cycles");
    back_acq_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == sar_pkg::DONE && fillReady) |=> state == sar_pkg::ACQ && !busy && powerDown)
        else $error("no return to acquisition after last decision");
    busy_ind_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == sar_pkg::STEP && !cnvLevel) |=> busy)
        else $error("busy indicator not shown with start input low");
    power_down_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == sar_pkg::ACQ |-> powerDown && positiveSampleGroundSwitch)
        else $error("not powered down between conversions");
    result_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == sar_pkg::DONE && bufCount == 2'h0 && !frameLevel ##1 !frameLevel)
        |=> holdCode == fmtCode($past(dacTrial, 2), $past(cfgUsed[sar_pkg::CFG_BIPOLAR_BIT], 2)))
        else $error("finished code not latched for readout");
    cfg_apply_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfgEvt |=> cfgActive == $past(cfgXfer))
        else $error("configuration write not applied");
endmodule // sar_conversion_sequencer

// ### logic/sar_pkg.sv
// Constants and state encoding for the conversion sequencer
package sar_pkg;
    localparam int CLK_NS = 5;
    localparam int CODE_W = 16;
    localparam int CFG_W = 14;
    localparam int FRAME_W = CODE_W + CFG_W;
    // Internal conversion clock period, one decision per period
    localparam int CONV_TICK_NS = 20;
    localparam int CONV_TICK_CYC = (CONV_TICK_NS + CLK_NS - 1) / CLK_NS;
    // Least spacing between two starts, 250 kSPS
    localparam int START_GAP_NS = 4000;
    localparam int START_GAP_CYC = (START_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_W = 3;
    localparam int GAP_W = 10;
    localparam int BIT_W = 4;
    localparam int LCNT_W = 5;
    localparam int STEP_W = 8;
    // Configuration word layout and reset value
    localparam int CFG_READBACK_BIT = 0;
    localparam int CFG_BIPOLAR_BIT = 1;
    localparam logic [13:0] CFG_RESET = 14'h0000;
    localparam logic [15:0] CODE_MSB = 16'h8000;
    typedef enum logic [2:0] {
        ACQ = 3'b000,
        OPEN = 3'b001,
        HOLD = 3'b010,
        STEP = 3'b011,
        DONE = 3'b100
    } sar_state_t;
endpackage

// ### sim/sar_conversion_sequencer_tb.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module sar_conversion_sequencer_tb;
    logic clk, rst_n, compHigh, conversionStartInput, sck, sdi;
    logic sdo, sdoEn, busy, posSw, negSw, arraysToInputs, powerDown, busySeen;
    logic [15:0] dacTrial, target;
    int errors, compares, cyc, sinceStart;

    sar_conversion_sequencer dut_u (
        .clk(clk),
        .rst_n(rst_n),
        .conversionStartInput(conversionStartInput),
        .compHigh(compHigh),
        .sck(sck),
        .sdi(sdi),
        .sdo(sdo),
        .sdoEn(sdoEn),
        .busy(busy),
        .positiveSampleGroundSwitch(posSw),
        .negativeSampleGroundSwitch(negSw),
        .arraysToInputs(arraysToInputs),
        .dacTrial(dacTrial),
        .powerDown(powerDown)
    );

    sar_host_model host_u (
        .clk(clk),
        .sdo(sdo),
        .conversionStartInput(conversionStartInput),
        .sck(sck),
        .sdi(sdi)
    );

    always #2.5 clk = ~clk;

    // Comparator: trial above the held input clears the bit
    always @(negedge clk) begin
        compHigh <= (dacTrial > target);
    end

    always @(posedge clk) begin
        cyc++;
        sinceStart++;
        if (busy === 1'b1) begin
            busySeen = 1'b1;
        end
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic waitLevel(ref logic s, input logic v, input int lim, input string msg);
        int n;
        n = 0;
        while (s !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        check(s === v, msg);
    endtask

    // Keeps the least start spacing, then launches the start pulse
    task automatic startConv(input logic [15:0] t, input int hold);
        int n;
        n = 0;
        while (sinceStart < 820 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        target = t;
        busySeen = 1'b0;
        sinceStart = 0;
        fork
            host_u.pulse(hold);
        join_none
    endtask

    task automatic checkConv(input logic [15:0] t);
        waitLevel(posSw, 1'b0, 20, "switches did not open");
        check(sdoEn === 1'b0, "output enabled with start high");
        check(arraysToInputs === 1'b1 && negSw === 1'b0, "arrays moved first");
        check(powerDown === 1'b0, "powered down in conversion");
        waitLevel(arraysToInputs, 1'b0, 10, "arrays not grounded");
        repeat (4) @(negedge clk);
        check(dacTrial === sar_pkg::CODE_MSB, "first trial not MSB");
        waitLevel(powerDown, 1'b1, 120, "conversion did not end");
        check(dacTrial === t && posSw === 1'b1, "wrong code or phase");
        check(busySeen === 1'b1, "busy not shown");
    endtask

    task automatic readFrame(input logic [13:0] cfg, input logic [29:0] exp, input string msg);
        logic [29:0] rx;
        host_u.frame(cfg, rx);
        check(rx === exp && sdoEn === 1'b1, msg);
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        target = 16'h0000;
        busySeen = 1'b0;
        errors = 0;
        compares = 0;
        cyc = 0;
        sinceStart = 1000;
        repeat (12) @(negedge clk);
        check(posSw === 1'b1 && negSw === 1'b1 && powerDown === 1'b1, "reset switches");
        check(busy === 1'b0 && dacTrial === 16'h0000, "reset outputs");
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        startConv(16'h1234, 6);
        checkConv(16'h1234);
        check(sck === 1'b0, "conversion needed serial clock");
        readFrame(14'h0001, {16'h1234, 14'h0000}, "result after conversion");
        startConv(16'hBEEF, 6);
        checkConv(16'hBEEF);
        readFrame(14'h0003, {16'hBEEF, 14'h0001}, "config readback");
        startConv(16'h00F0, 6);
        fork
            checkConv(16'h00F0);
            begin
                repeat (10) @(negedge clk);
                readFrame(14'h0003, {16'hBEEF, 14'h0001}, "read during conversion");
            end
        join
        host_u.pulse(8);
        repeat (30) @(negedge clk);
        check(posSw === 1'b1, "start inside spacing accepted");
        readFrame(14'h0003, {16'h80F0, 14'h0003}, "bipolar result");
        // Start held high through the whole conversion: no busy indication
        startConv(16'h0F0F, 100);
        waitLevel(powerDown, 1'b0, 20, "long start not taken");
        waitLevel(powerDown, 1'b1, 120, "long conversion did not end");
        check(dacTrial === 16'h0F0F && busySeen === 1'b0, "busy shown with start high");
        summarize();
    end
endmodule // sar_conversion_sequencer_tb

// ### sim/sar_host_model.sv
// Host controller model: start pin and serial port of the far side
`timescale 1ns/10ps
module sar_host_model (
    input wire logic clk,
    input wire logic sdo,
    output logic conversionStartInput,
    output logic sck,
    output logic sdi
);
    initial begin
        conversionStartInput = 1'b0;
        sck = 1'b0;
        sdi = 1'b1;
    end

    // Rising edge held some cycles, then low so busy is shown
    task automatic pulse(input int hold);
        @(negedge clk);
        conversionStartInput = 1'b1;
        repeat (hold) @(negedge clk);
        conversionStartInput = 1'b0;
    endtask

    // One 30-edge frame; the first 14 bits sent carry the config word
    task automatic frame(input logic [13:0] cfg, output logic [29:0] rx);
        logic [29:0] tx;
        tx = {cfg, 16'h0000};
        rx = '0;
        for (int i = 0; i < 30; i++) begin
            sdi = tx[29 - i];
            #24;
            rx = {rx[28:0], sdo};
            sck = 1'b1;
            #24;
            sck = 1'b0;
        end
        // Toggled data line no longer shows the last bit
        sdi = ~sdi;
    endtask
endmodule // sar_host_model
